// ---- verif/aux_load_monitor.sv ----
/*
 Load on one pulse pin: measures the last high time and the last period in clocks.
 Assumes the pin is driven from flip-flops on the same clock.
*/
`timescale 1ns/1ns

module aux_load_monitor (
	input logic clk,
	input logic pulse,
	output logic [17:0] highLen,
	output logic [17:0] periodLen
);
	logic prev = 1'b0;
	logic [17:0] cnt = 18'h0;
	// ==========================================================================
	// Cycle counts between edges.
	always_ff @(posedge clk) begin
		prev <= pulse;
		cnt <= (pulse && !prev) ? 18'h1 : cnt + 18'h1;
		if (pulse && !prev) periodLen <= cnt;
		if (!pulse && prev) highLen <= cnt;
	end
endmodule

// ---- verif/aux_pwm_timers_bench.sv ----
/*
 Bench for the dual pulse timers: bus tasks, pin loads and directed tests.
 Assumes the checker and the load monitor are compiled before it.
*/
`timescale 1ns/1ns
`include "aux_pwm_cfg.svh"

module aux_pwm_timers_bench;
	import aux_pwm_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	axi_resp_t s_axi_bresp, s_axi_rresp;
	logic auxPulseOutA, auxPulseOutB;
	logic [17:0] hiA, perA, hiB, perB;
	int failCount = 0;
	int testsRun = 0;
	int n;
	time t;

	aux_pwm_timers aux_pwm_timers_inst (.clk, .srst, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .auxPulseOutA, .auxPulseOutB);
	aux_load_monitor loadA (.clk, .pulse(auxPulseOutA), .highLen(hiA), .periodLen(perA));
	aux_load_monitor loadB (.clk, .pulse(auxPulseOutB), .highLen(hiB), .periodLen(perB));

	initial begin
		forever #5 clk = ~clk;
	end
	// ==========================================================================
	// Compare, bus and closing tasks.
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		testsRun++;
		if (s !== e) begin
			failCount++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input axi_resp_t e);
		bit ta = 0;
		bit tw = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (!ta && s_axi_awready) begin
				ta = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!tw && s_axi_wready) begin
				tw = 1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!s_axi_bvalid);
		chk("bresp", s_axi_bresp, e);
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input axi_resp_t e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk("rdata", s_axi_rdata, d);
		chk("rresp", s_axi_rresp, e);
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic mon(input int pa, input int ha, input int pb, input int hb);
		chk("periodA", perA, pa);
		chk("highA", hiA, ha);
		chk("periodB", perB, pb);
		chk("highB", hiB, hb);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ==========================================================================
	// Tests and watchdog.
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 5; i++) rd(8'(4 * i), i < 2 ? 32'hFFFF : 32'h0, RESP_OKAY);
		rd(8'h20, 32'h0, RESP_SLVERR);
		wr(`AUX_OFF_STATUS, 32'h7, RESP_SLVERR);
		wr(`AUX_OFF_PERIOD_CH1, 32'h0, RESP_OKAY);
		rd(`AUX_OFF_PERIOD_CH1, 32'h0, RESP_OKAY);
		$display("test reset done");
		wr(`AUX_OFF_MODE_CTRL, 32'h100, RESP_OKAY);
		wr(`AUX_OFF_ONTIME_CH0, 32'h3, RESP_OKAY);
		wr(`AUX_OFF_ONTIME_CH1, 32'h2, RESP_OKAY);
		wr(`AUX_OFF_PERIOD_CH0, 32'h5, RESP_OKAY);
		wr(`AUX_OFF_PERIOD_CH1, 32'h9, RESP_OKAY);
		repeat (100) @(posedge clk);
		mon(12, 6, 20, 4);
		rd(`AUX_OFF_MODE_CTRL, 32'h100, RESP_OKAY);
		wr(`AUX_OFF_ONTIME_CH0, 32'h1, RESP_OKAY);
		repeat (80) @(posedge clk);
		chk("highA", hiA, 2);
		wr(`AUX_OFF_ONTIME_CH0, 32'h7, RESP_OKAY);
		wr(`AUX_OFF_ONTIME_CH1, 32'h0, RESP_OKAY);
		repeat (80) @(posedge clk);
		chk("fullA", auxPulseOutA, 1);
		chk("zeroB", auxPulseOutB, 0);
		$display("test independent done");
		wr(`AUX_OFF_ONTIME_CH0, 32'h2, RESP_OKAY);
		wr(`AUX_OFF_PERIOD_CH0, 32'd60, RESP_OKAY);
		repeat (30) @(posedge clk);
		wr(`AUX_OFF_PERIOD_CH0, 32'd60, RESP_OKAY);
		n = 0;
		while (!auxPulseOutA && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk("restartA", n <= 5, 1);
		$display("test restart done");
		wr(`AUX_OFF_MODE_CTRL, 32'h0, RESP_OKAY);
		wr(`AUX_OFF_PERIOD_CH0, 32'h7, RESP_OKAY);
		wr(`AUX_OFF_PERIOD_CH1, 32'h2, RESP_OKAY);
		wr(`AUX_OFF_ONTIME_CH0, 32'h3, RESP_OKAY);
		wr(`AUX_OFF_ONTIME_CH1, 32'h2, RESP_OKAY);
		repeat (100) @(posedge clk);
		mon(16, 6, 16, 4);
		@(posedge auxPulseOutA);
		t = $time;
		@(posedge auxPulseOutB);
		chk("offsetB", 32'(($time - t) / 10), 6);
		$display("test offset done");
		@(posedge clk);
		summarize();
	end
	initial begin
		repeat (5000) @(posedge clk);
		failCount++;
		summarize();
	end
endmodule

bind aux_pwm_timers aux_pwm_timers_chk #(.ADDR_W(ADDR_W)) aux_pwm_timers_chk_inst (.clk, .srst,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.auxPulseOutA, .auxPulseOutB);

// ---- verif/aux_pwm_timers_chk.sv ----
/*
 Checker for the dual pulse timers, watching only the top ports.
 Assumes full-word register writes and one write in flight at a time.
*/
`timescale 1ns/1ns
`include "aux_pwm_cfg.svh"

module aux_pwm_timers_chk #(
	parameter int ADDR_W = 8
) (
	input logic clk,
	input logic srst,
	input logic [ADDR_W-1:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input aux_pwm_pkg::axi_resp_t s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic auxPulseOutA,
	input logic auxPulseOutB
);
	import aux_pwm_pkg::*;
	// ==========================================================================
	// Register copies taken from the bus, edge counters and a quiet timer.
	logic [ADDR_W-1:0] wa;
	logic [31:0] wd;
	logic [15:0] p0, p1, o0, o1;
	logic md, pa, pb, wrOk, ok, aOk, bOk;
	logic [17:0] ca, cb, la, lb;
	logic [19:0] q;
	assign wrOk = s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY;
	assign la = {1'b0, p0, 1'b0} + 18'h2;
	assign lb = {1'b0, p1, 1'b0} + 18'h2;
	assign ok = q > {1'b0, la, 1'b0} + {1'b0, lb, 1'b0};
	assign aOk = o0 != 16'h0 && o0 <= p0;
	assign bOk = o1 != 16'h0 && o1 <= (md ? p1 : p0);
	always_ff @(posedge clk) begin
		if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			p0 <= `AUX_PERIOD_RESET;
			p1 <= `AUX_PERIOD_RESET;
			o0 <= `AUX_ONTIME_RESET;
			o1 <= `AUX_ONTIME_RESET;
			md <= `AUX_MODE_RESET;
		end else if (wrOk) begin
			case (wa)
			`AUX_OFF_PERIOD_CH0: p0 <= wd[15:0];
			`AUX_OFF_PERIOD_CH1: p1 <= wd[15:0];
			`AUX_OFF_ONTIME_CH0: o0 <= wd[15:0];
			`AUX_OFF_ONTIME_CH1: o1 <= wd[15:0];
			`AUX_OFF_MODE_CTRL: md <= wd[`AUX_MODE_INDEP_BIT];
			default: ;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		pa <= auxPulseOutA;
		pb <= auxPulseOutB;
		ca <= (auxPulseOutA && !pa) ? 18'h1 : ca + 18'h1;
		cb <= (auxPulseOutB && !pb) ? 18'h1 : cb + 18'h1;
		q <= (srst || wrOk) ? 20'h0 : q + {19'h0, q != 20'hFFFFF};
	end
	// ==========================================================================
	// Assertions.
	default clocking dc @(posedge clk); endclocking
	default disable iff (srst);
	sequence riseA;
		ok && aOk && $rose(auxPulseOutA);
	endsequence
	sequence riseB;
		ok && bOk && $rose(auxPulseOutB);
	endsequence
	sequence periodWrite;
		wrOk && wa == `AUX_OFF_PERIOD_CH0 && o0 != 16'h0;
	endsequence
	reset_low_a: assert property ($fell(srst) |-> !auxPulseOutA && !auxPulseOutB)
		else $error("pulse output high after reset");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	period_a_a: assert property (riseA |-> ca == la)
		else $error("channel A period wrong");
	high_a_a: assert property (ok && aOk && $fell(auxPulseOutA) |-> ca == {1'b0, o0, 1'b0})
		else $error("channel A high time wrong");
	period_b_a: assert property (riseB |-> cb == (md ? lb : la))
		else $error("channel B period wrong");
	high_b_a: assert property (ok && bOk && $fell(auxPulseOutB) |-> cb == {1'b0, o1, 1'b0})
		else $error("channel B high time wrong");
	offset_b_a: assert property (riseB and (!md && aOk && p1 < p0) |-> ca == lb)
		else $error("channel B offset wrong");
	full_on_a: assert property (ok && o0 > p0 |-> auxPulseOutA)
		else $error("channel A not held high");
	zero_on_a: assert property (ok && o1 == 16'h0 |-> !auxPulseOutB)
		else $error("channel B high at zero on-time");
	restart_a_a: assert property (periodWrite |-> ##[0:4] auxPulseOutA)
		else $error("period write did not restart channel A");
endmodule

// ---- verilog/aux_pwm_cfg.svh ----
/*
 Constants for the dual auxiliary pulse-width timers: register offsets, field
 positions, reset values and the timing unit. Assumes a 100 MHz instruction clock.
*/
`ifndef AUX_PWM_CFG_SVH
`define AUX_PWM_CFG_SVH

// ==========================================================================
// Register map
`define AUX_OFF_PERIOD_CH0 8'h00
`define AUX_OFF_PERIOD_CH1 8'h04
`define AUX_OFF_ONTIME_CH0 8'h08
`define AUX_OFF_ONTIME_CH1 8'h0C
`define AUX_OFF_MODE_CTRL 8'h10
`define AUX_OFF_STATUS 8'h14
`define AUX_OFF_COUNT_CH0 8'h18
`define AUX_OFF_COUNT_CH1 8'h1C

// ==========================================================================
// Fields and reset values
`define AUX_MODE_INDEP_BIT 8
`define AUX_STAT_OUT_A_BIT 0
`define AUX_STAT_OUT_B_BIT 1
`define AUX_STAT_WAIT_B_BIT 2
`define AUX_PERIOD_RESET 16'hFFFF
`define AUX_ONTIME_RESET 16'h0000
`define AUX_MODE_RESET 1'b0

// ==========================================================================
// Timing
`define AUX_CLK_PERIOD_NS 10
`define AUX_TICK_DIV 2

`endif

// ---- verilog/aux_pwm_channel.sv ----
/*
 One auxiliary pulse channel: period counter, on-time shadow and start delay.
 Assumes tick is the timing-unit enable and restart a one-cycle pulse.
*/
`timescale 1ns/1ns
`include "aux_pwm_cfg.svh"

module aux_pwm_channel #(
	parameter bit RESET_WAIT = 1'b0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic tick,
	input wire logic restart,
	input wire logic [15:0] periodVal,
	input wire logic [15:0] onTimeVal,
	input wire logic [15:0] delayVal,
	input wire logic delayEn,
	output logic pulseOut,
	output logic [15:0] count,
	output logic waiting
);
	import aux_pwm_pkg::*;

	chan_phase_t phase_reg;
	logic [15:0] cnt_reg;
	logic [15:0] onShadow_reg;
	logic [15:0] waitCnt_reg;
	logic pulse_reg;

	// ======================================================================
	// Counter, start delay and on-time shadow.
	always_ff @(posedge clk) begin
		if (srst) begin
			phase_reg <= RESET_WAIT ? PH_WAIT : PH_RUN;
			cnt_reg <= 16'h0000;
			onShadow_reg <= `AUX_ONTIME_RESET;
			waitCnt_reg <= `AUX_PERIOD_RESET;
		end else if (restart) begin
			cnt_reg <= 16'h0000;
			onShadow_reg <= onTimeVal;
			waitCnt_reg <= delayVal;
			phase_reg <= delayEn ? PH_WAIT : PH_RUN;
		end else if (tick) begin
			unique case (phase_reg)
				PH_WAIT: begin
					if (waitCnt_reg == 16'h0000) begin
						phase_reg <= PH_RUN;
						cnt_reg <= 16'h0000;
						onShadow_reg <= onTimeVal;
					end else begin
						waitCnt_reg <= waitCnt_reg - 16'h0001;
					end
				end
				PH_RUN: begin
					if (cnt_reg >= periodVal) begin
						cnt_reg <= 16'h0000;
						onShadow_reg <= onTimeVal;
					end else begin
						cnt_reg <= cnt_reg + 16'h0001;
					end
				end
			endcase
		end
	end

	// ======================================================================
	// Output is high while running and the count is below the on-time shadow.
	always_ff @(posedge clk) begin
		if (srst) begin
			pulse_reg <= 1'b0;
		end else begin
			pulse_reg <= (phase_reg == PH_RUN) && (cnt_reg < onShadow_reg);
		end
	end

	assign pulseOut = pulse_reg;
	assign count = cnt_reg;
	assign waiting = (phase_reg == PH_WAIT);

endmodule

// ---- verilog/aux_pwm_pkg.sv ----
/*
 Types shared by the auxiliary pulse-width timers.
 Assumes the constants header is included by the design files that need it.
*/
package aux_pwm_pkg;

	// ======================================================================
	// Channel phase and bus responses
	typedef enum logic [0:0] {
		PH_RUN = 1'b0,
		PH_WAIT = 1'b1
	} chan_phase_t;

	typedef enum logic [1:0] {
		RESP_OKAY = 2'b00,
		RESP_SLVERR = 2'b10
	} axi_resp_t;

endpackage

// ---- verilog/aux_pwm_timers.sv ----
/*
 Top of the dual auxiliary pulse-width timers with an AXI4-Lite register slave.
 Assumes one 100 MHz clock, synchronous reset and a well-behaved bus master.
*/
`timescale 1ns/1ns
`include "aux_pwm_cfg.svh"

module aux_pwm_timers #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output aux_pwm_pkg::axi_resp_t s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output aux_pwm_pkg::axi_resp_t s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic auxPulseOutA,
	output logic auxPulseOutB
);
	import aux_pwm_pkg::*;

	// ======================================================================
	// Declarations
	logic [15:0] auxPeriodCh0_reg;
	logic [15:0] auxPeriodOrOffsetCh1_reg;
	logic [15:0] auxOntimeCh0_reg;
	logic [15:0] auxOntimeCh1_reg;
	logic modeIndep_reg;
	logic restart_reg;

	logic awHeld_reg;
	logic [ADDR_W-1:0] awAddr_reg;
	logic wHeld_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic bvalid_reg;
	axi_resp_t bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	axi_resp_t rresp_reg;

	logic awFire;
	logic wFire;
	logic wrGo;
	logic arFire;
	logic [ADDR_W-1:0] wrAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic wrPeriod;
	logic wrMode;
	logic modeNext;

	logic tick;
	logic pulseA;
	logic pulseB;
	logic waitB;
	logic [15:0] countA;
	logic [15:0] countB;
	logic [15:0] periodB;

	// ======================================================================
	// Helpers
	function automatic logic [15:0] mergeBytes(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	function automatic logic isWritable(input logic [ADDR_W-1:0] addr);
		logic hit;
		hit = 1'b0;
		unique case (addr)
			ADDR_W'(`AUX_OFF_PERIOD_CH0),
			ADDR_W'(`AUX_OFF_PERIOD_CH1),
			ADDR_W'(`AUX_OFF_ONTIME_CH0),
			ADDR_W'(`AUX_OFF_ONTIME_CH1),
			ADDR_W'(`AUX_OFF_MODE_CTRL): hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// ======================================================================
	// Write channel handshake: address and data are taken in either order.
	assign s_axi_awready = !awHeld_reg && !bvalid_reg;
	assign s_axi_wready = !wHeld_reg && !bvalid_reg;
	assign awFire = s_axi_awvalid && s_axi_awready;
	assign wFire = s_axi_wvalid && s_axi_wready;
	assign wrGo = (awHeld_reg || awFire) && (wHeld_reg || wFire);
	assign wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
	assign wrData = wHeld_reg ? wData_reg : s_axi_wdata;
	assign wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;

	always_ff @(posedge clk) begin
		if (srst) begin
			awHeld_reg <= 1'b0;
			awAddr_reg <= '0;
		end else if (wrGo) begin
			awHeld_reg <= 1'b0;
		end else if (awFire) begin
			awHeld_reg <= 1'b1;
			awAddr_reg <= s_axi_awaddr;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wHeld_reg <= 1'b0;
			wData_reg <= 32'h00000000;
			wStrb_reg <= 4'h0;
		end else if (wrGo) begin
			wHeld_reg <= 1'b0;
		end else if (wFire) begin
			wHeld_reg <= 1'b1;
			wData_reg <= s_axi_wdata;
			wStrb_reg <= s_axi_wstrb;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (wrGo) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= isWritable(wrAddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// ======================================================================
	// Register file: writes are accepted at any time while running.
	always_ff @(posedge clk) begin
		if (srst) begin
			auxPeriodCh0_reg <= `AUX_PERIOD_RESET;
			auxPeriodOrOffsetCh1_reg <= `AUX_PERIOD_RESET;
		end else if (wrGo) begin
			if (wrAddr == ADDR_W'(`AUX_OFF_PERIOD_CH0)) begin
				auxPeriodCh0_reg <= mergeBytes(auxPeriodCh0_reg, wrData, wrStrb);
			end
			if (wrAddr == ADDR_W'(`AUX_OFF_PERIOD_CH1)) begin
				auxPeriodOrOffsetCh1_reg <= mergeBytes(auxPeriodOrOffsetCh1_reg, wrData, wrStrb);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			auxOntimeCh0_reg <= `AUX_ONTIME_RESET;
			auxOntimeCh1_reg <= `AUX_ONTIME_RESET;
		end else if (wrGo) begin
			if (wrAddr == ADDR_W'(`AUX_OFF_ONTIME_CH0)) begin
				auxOntimeCh0_reg <= mergeBytes(auxOntimeCh0_reg, wrData, wrStrb);
			end
			if (wrAddr == ADDR_W'(`AUX_OFF_ONTIME_CH1)) begin
				auxOntimeCh1_reg <= mergeBytes(auxOntimeCh1_reg, wrData, wrStrb);
			end
		end
	end

	assign wrMode = wrGo && (wrAddr == ADDR_W'(`AUX_OFF_MODE_CTRL)) && wrStrb[1];
	assign modeNext = wrData[`AUX_MODE_INDEP_BIT];

	always_ff @(posedge clk) begin
		if (srst) begin
			modeIndep_reg <= `AUX_MODE_RESET;
		end else if (wrMode) begin
			modeIndep_reg <= modeNext;
		end
	end

	// ======================================================================
	// Restart: a period write, or a change of mode, clears the counters.
	// It is delayed one cycle so the channels load the freshly written values.
	assign wrPeriod = wrGo && ((wrAddr == ADDR_W'(`AUX_OFF_PERIOD_CH0)) ||
		(wrAddr == ADDR_W'(`AUX_OFF_PERIOD_CH1)));

	always_ff @(posedge clk) begin
		if (srst) begin
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= wrPeriod || (wrMode && (modeNext != modeIndep_reg));
		end
	end

	// ======================================================================
	// Read channel: one cycle from address to data.
	assign s_axi_arready = !rvalid_reg;
	assign arFire = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge clk) begin
		if (srst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else if (arFire) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_W'(`AUX_OFF_PERIOD_CH0): rdata_reg <= {16'h0000, auxPeriodCh0_reg};
				ADDR_W'(`AUX_OFF_PERIOD_CH1): rdata_reg <= {16'h0000, auxPeriodOrOffsetCh1_reg};
				ADDR_W'(`AUX_OFF_ONTIME_CH0): rdata_reg <= {16'h0000, auxOntimeCh0_reg};
				ADDR_W'(`AUX_OFF_ONTIME_CH1): rdata_reg <= {16'h0000, auxOntimeCh1_reg};
				ADDR_W'(`AUX_OFF_MODE_CTRL): begin
					rdata_reg <= 32'(modeIndep_reg) << `AUX_MODE_INDEP_BIT;
				end
				ADDR_W'(`AUX_OFF_STATUS): begin
					rdata_reg <= {29'h00000000, waitB, pulseB, pulseA};
				end
				ADDR_W'(`AUX_OFF_COUNT_CH0): rdata_reg <= {16'h0000, countA};
				ADDR_W'(`AUX_OFF_COUNT_CH1): rdata_reg <= {16'h0000, countB};
				default: begin
					rdata_reg <= 32'h00000000;
					rresp_reg <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// ======================================================================
	// Timing unit of two instruction clocks.
	aux_tick_divider #(
		.DIV(`AUX_TICK_DIV)
	) u_tick (
		.clk(clk),
		.srst(srst),
		.restart(restart_reg),
		.tick(tick)
	);

	// ======================================================================
	// Channel A always runs on its own period and on-time.
	aux_pwm_channel #(
		.RESET_WAIT(1'b0)
	) u_chan_a (
		.clk(clk),
		.srst(srst),
		.tick(tick),
		.restart(restart_reg),
		.periodVal(auxPeriodCh0_reg),
		.onTimeVal(auxOntimeCh0_reg),
		.delayVal(16'h0000),
		.delayEn(1'b0),
		.pulseOut(pulseA),
		.count(countA),
		.waiting()
	);

	// ======================================================================
	// Channel B: own period when independent, else common period after offset.
	assign periodB = modeIndep_reg ? auxPeriodOrOffsetCh1_reg : auxPeriodCh0_reg;

	aux_pwm_channel #(
		.RESET_WAIT(1'b1)
	) u_chan_b (
		.clk(clk),
		.srst(srst),
		.tick(tick),
		.restart(restart_reg),
		.periodVal(periodB),
		.onTimeVal(auxOntimeCh1_reg),
		.delayVal(auxPeriodOrOffsetCh1_reg),
		.delayEn(!modeIndep_reg),
		.pulseOut(pulseB),
		.count(countB),
		.waiting(waitB)
	);

	assign auxPulseOutA = pulseA;
	assign auxPulseOutB = pulseB;

endmodule

// ---- verilog/aux_tick_divider.sv ----
/*
 Divider that makes the one-cycle timing-unit enable from the instruction clock.
 Assumes restart is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ns
`include "aux_pwm_cfg.svh"

module aux_tick_divider #(
	parameter int DIV = `AUX_TICK_DIV
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic restart,
	output logic tick
);
	import aux_pwm_pkg::*;

	logic [7:0] div_reg;

	// ======================================================================
	// Phase counter, realigned on every restart.
	always_ff @(posedge clk) begin
		if (srst || restart) begin
			div_reg <= 8'h00;
		end else if (tick) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	assign tick = (div_reg == 8'(DIV - 1));

endmodule
